// >>> design/sfs_serializer.sv
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "sfs_consts.svh"

module sfs_serializer
   import sfs_pkg::*;
(
   // Core clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Parallel side, transmit clock domain
   input wire logic tx_clock_in,
   input wire logic [9:0] parallel_in,
   // Control pins
   input wire logic capture_edge_select,
   input wire logic serial_output_enable,
   input wire logic sleep_request_n,
   input wire logic align_request_a,
   input wire logic align_request_b,
   // Serial line
   output logic serial_out_p,
   output logic serial_out_n,
   output logic serial_oe_n
);

   // ----------------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------------
   logic rst_s1;
   logic rst_n;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // ----------------------------------------------------------------------
   // Capture in the transmit clock domain
   // ----------------------------------------------------------------------
   // Both edges capture; the core picks the selected one, so no control pin is
   // read in this domain without a synchroniser.
   logic [9:0] word_r;
   logic [9:0] word_f;
   logic tog_r;
   logic tog_f;
   always_ff @(posedge tx_clock_in or negedge nrst) begin
      if (!nrst) begin
         word_r <= 10'h000;
         tog_r <= 1'b0;
      end else begin
         word_r <= parallel_in;
         tog_r <= !tog_r;
      end
   end
   always_ff @(negedge tx_clock_in or negedge nrst) begin
      if (!nrst) begin
         word_f <= 10'h000;
         tog_f <= 1'b0;
      end else begin
         word_f <= parallel_in;
         tog_f <= !tog_f;
      end
   end

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   sfs_pins_type pins_raw;
   sfs_pins_type pins_s1;
   sfs_pins_type pins;
   assign pins_raw = '{capture_edge_select, serial_output_enable, sleep_request_n,
                       align_request_a, align_request_b, tog_r, tog_f};
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pins_s1 <= '0;
         pins <= '0;
      end else begin
         pins_s1 <= pins_raw;
         pins <= pins_s1;
      end
   end

   // ----------------------------------------------------------------------
   // Capture events and lock
   // ----------------------------------------------------------------------
   logic tog_seen;
   logic [9:0] lock_cnt;
   logic [9:0] pend_word;
   logic pll_locked;
   logic hiz;
   logic hiz_q;
   wire tog_sel = pins.edge_sel ? pins.tog_r : pins.tog_f;
   wire cap_evt = tog_sel != tog_seen;
   wire [9:0] word_sel = pins.edge_sel ? word_r : word_f;
   assign pll_locked = lock_cnt == `SFS_LOCK_PERIODS;
   assign hiz = !pll_locked || !pins.out_en || !pins.sleep_n;
   wire [9:0] next_lock_cnt = (!pins.sleep_n) ? 10'h000 :
                              (cap_evt && !pll_locked) ? lock_cnt + 10'h001 : lock_cnt;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tog_seen <= 1'b0;
         lock_cnt <= 10'h000;
         pend_word <= 10'h000;
         hiz_q <= 1'b1;
      end else begin
         tog_seen <= tog_sel;
         lock_cnt <= next_lock_cnt;
         if (cap_evt) begin
            pend_word <= word_sel;
         end
         hiz_q <= hiz;
      end
   end

   // ----------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------
   logic [1:0] ctrl;
   logic [15:0] frames;
   logic req_any_q;
   logic [10:0] align_left;
   wire apb_setup = psel && !penable && !pready;
   wire apb_done = psel && penable && pready;
   wire hit_ctrl = paddr == `SFS_CTRL_OFFSET;
   wire hit_status = paddr == `SFS_STATUS_OFFSET;
   wire hit_frames = paddr == `SFS_FRAMES_OFFSET;
   wire hit_any = hit_ctrl || hit_status || hit_frames;
   wire sending_align = req_any_q || align_left != 11'h000;
   wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl} :
                        hit_status ? {28'h0, pins.edge_sel, hiz_q, sending_align, pll_locked} :
                        hit_frames ? {16'h0, frames} : 32'h0;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
         ctrl <= `SFS_CTRL_RESET;
      end else begin
         pready <= apb_setup;
         pslverr <= apb_setup && !hit_any;
         prdata <= (apb_setup && !pwrite) ? rd_mux : 32'h0;
         if (apb_done && pwrite && hit_ctrl) begin
            ctrl <= pwdata[1:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Alignment requests
   // ----------------------------------------------------------------------
   wire req_any = pins.req_a || pins.req_b || ctrl[`SFS_CTRL_ALIGN_BIT];
   wire req_rise = req_any && !req_any_q;
   wire hiz_exit = hiz_q && !hiz;
   wire load_frame = cap_evt && !hiz;
   wire [10:0] next_align_left =
      (req_rise || (hiz_exit && ctrl[`SFS_CTRL_AUTO_BIT])) ? `SFS_ALIGN_MIN :
      (load_frame && align_left != 11'h000) ? align_left - 11'h001 : align_left;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_any_q <= 1'b0;
         align_left <= 11'h000;
      end else begin
         req_any_q <= req_any;
         align_left <= next_align_left;
      end
   end

   // ----------------------------------------------------------------------
   // Framing and shifting
   // ----------------------------------------------------------------------
   // The held word goes out at the next capture, one transmit period after
   // its own strobe; each frame carries a start and a stop clock bit.
   sfs_tx_state_type state;
   logic [11:0] shreg;
   logic [3:0] bits_left;
   wire use_align = req_any || align_left != 11'h000;
   wire [9:0] frame_body = use_align ? `SFS_ALIGN_PATTERN : pend_word;
   wire [11:0] frame_word = {`SFS_CLK_START, frame_body, `SFS_CLK_STOP};
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= SFS_TX_IDLE;
         shreg <= 12'h000;
         bits_left <= 4'h0;
         frames <= 16'h0000;
      end else if (load_frame) begin
         state <= SFS_TX_SHIFT;
         shreg <= frame_word;
         bits_left <= 4'hB;
         frames <= frames + 16'h0001;
      end else if (hiz) begin
         state <= SFS_TX_IDLE;
         shreg <= 12'h000;
         bits_left <= 4'h0;
      end else begin
         unique case (state)
            SFS_TX_IDLE: begin
               shreg <= shreg;
            end
            SFS_TX_SHIFT: begin
               shreg <= {shreg[10:0], 1'b0};
               bits_left <= bits_left - 4'h1;
               if (bits_left == 4'h0) begin
                  state <= SFS_TX_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Serial line drivers
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         serial_out_p <= 1'b0;
         serial_out_n <= 1'b1;
         serial_oe_n <= 1'b1;
      end else begin
         serial_out_p <= shreg[11] && !hiz;
         serial_out_n <= !(shreg[11] && !hiz);
         serial_oe_n <= hiz;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   logic [9:0] evt_since;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         evt_since <= 10'h000;
      end else if (!pins.sleep_n) begin
         evt_since <= 10'h000;
      end else if (cap_evt && evt_since != 10'h3FF) begin
         evt_since <= evt_since + 10'h001;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_load_frame;
      load_frame;
   endsequence
   sequence s_align_start;
      req_rise;
   endsequence
   sequence s_wake;
      hiz_exit && ctrl[`SFS_CTRL_AUTO_BIT];
   endsequence

   a_frame_clock_bits: assert property (s_load_frame |=> shreg[11] && !shreg[0])
      else $error("frame lacks embedded clock bits");
   a_align_replace: assert property (s_load_frame and req_any |=> shreg[10:1] == `SFS_ALIGN_PATTERN)
      else $error("alignment pattern not sent on request");
   a_lock_window: assert property ($rose(pll_locked) |->
      evt_since >= `SFS_LOCK_MIN && evt_since <= `SFS_LOCK_MAX)
      else $error("lock outside allowed period window");
   a_start_delay: assert property (s_load_frame ##1 !load_frame && !hiz |=> serial_out_p)
      else $error("frame start bit not driven on time");
   a_resync_burst: assert property (s_wake |=> align_left == `SFS_ALIGN_MIN)
      else $error("no alignment burst after high impedance");
   a_align_min: assert property (s_align_start |=> align_left == `SFS_ALIGN_MIN ##1 use_align)
      else $error("alignment burst not armed");
   // With the edge choice steady, a capture event follows only the chosen toggle.
   a_edge_rise: assert property (pins.edge_sel && $past(pins.edge_sel) |->
      cap_evt == $changed(pins.tog_r))
      else $error("rising edge capture event mismatch");
   a_edge_fall: assert property (!pins.edge_sel && !$past(pins.edge_sel) |->
      cap_evt == $changed(pins.tog_f))
      else $error("falling edge capture event mismatch");
   a_payload_body: assert property (s_load_frame and !use_align |=>
      shreg[10:1] == $past(pend_word))
      else $error("payload word not framed");
   a_align_burst: assert property (s_load_frame and align_left != 11'h000 |=>
      shreg[10:1] == `SFS_ALIGN_PATTERN)
      else $error("payload sent during alignment burst");
   a_no_frame_hiz: assert property (hiz |=> $stable(frames))
      else $error("frame sent in high impedance");
   a_lock_hold: assert property (pll_locked && pins.sleep_n |=> pll_locked)
      else $error("lock lost while awake");
   a_oe_hiz: assert property (!pins.out_en |=> serial_oe_n && !serial_out_p)
      else $error("output driven while disabled");
   a_sleep_hiz: assert property (!pins.sleep_n |=> serial_oe_n && lock_cnt == 10'h000)
      else $error("sleep did not stop lock and outputs");

endmodule
`default_nettype wire

// >>> design/sfs_consts.svh
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define SFS_CTRL_OFFSET 8'h00
`define SFS_STATUS_OFFSET 8'h04
`define SFS_FRAMES_OFFSET 8'h08
`define SFS_CTRL_ALIGN_BIT 0
`define SFS_CTRL_AUTO_BIT 1
`define SFS_CTRL_RESET 2'h2

// ----------------------------------------------------------------------
// Line coding and timing
// ----------------------------------------------------------------------
`define SFS_WORD_W 10
`define SFS_FRAME_W 12
`define SFS_CLK_START 1'h1
`define SFS_CLK_STOP 1'h0
`define SFS_ALIGN_PATTERN 10'h3E0
`define SFS_LOCK_PERIODS 10'h1FF
`define SFS_LOCK_MIN 10'h1FE
`define SFS_LOCK_MAX 10'h201
`define SFS_ALIGN_MIN 11'h400

`endif

// >>> design/sfs_pkg.sv
package sfs_pkg;
   typedef enum logic {SFS_TX_IDLE, SFS_TX_SHIFT} sfs_tx_state_type;
   typedef struct packed {
      logic edge_sel;
      logic out_en;
      logic sleep_n;
      logic req_a;
      logic req_b;
      logic tog_r;
      logic tog_f;
   } sfs_pins_type;
endpackage

// >>> verif/sfs_rx_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "sfs_consts.svh"

module sfs_rx_model (
   // Clock and reset
   input wire logic receiver_local_clock,
   input wire logic nrst,
   // Serial line
   input wire logic line_p,
   input wire logic line_oe_n,
   // Receiver side
   output logic lock_n,
   output logic rx_valid,
   output logic [9:0] receiver_parallel_out
);
   logic [3:0] cnt;
   logic [9:0] sh;
   logic [4:0] run;

   always_ff @(posedge receiver_local_clock or negedge nrst) begin
      if (!nrst) begin
         cnt <= 4'h0;
         sh <= 10'h000;
         run <= 5'h00;
         lock_n <= 1'h1;
         rx_valid <= 1'h0;
         receiver_parallel_out <= 10'h000;
      end else begin
         rx_valid <= 1'h0;
         if (line_oe_n) begin
            cnt <= 4'h0;
            run <= 5'h00;
            lock_n <= 1'h1;
         end else if (cnt == 4'h0) begin
            cnt <= {3'h0, line_p};
         end else if (cnt < 4'hB) begin
            sh <= {sh[8:0], line_p};
            cnt <= cnt + 4'h1;
         end else begin
            cnt <= 4'h0;
            rx_valid <= !line_p;
            receiver_parallel_out <= sh;
            run <= line_p ? 5'h00 : run + {4'h0, run != 5'h1F};
            if (line_p) begin
               lock_n <= 1'h1;
            end else if ((sh == `SFS_ALIGN_PATTERN && run > 5'h2) || run > 5'hE) begin
               lock_n <= 1'h0;
            end
         end
      end
   end
endmodule

`default_nettype wire

// >>> verif/serializer_framing_sync_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "sfs_consts.svh"

module serializer_framing_sync_tb;
   logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, er, tx_clock_in;
   logic capture_edge_select, serial_output_enable, sleep_request_n, align_request_b;
   logic serial_out_p, serial_out_n, serial_oe_n, lock_n, rx_valid, chk_on, resync, got_pay;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [9:0] parallel_in, rx_word;
   logic [9:0] exq[$];
   int fails, n_tests, cyc, n_align, skip, n, k;
   wire logic align_request_a = lock_n;

   sfs_serializer sfs_serializer_inst (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .tx_clock_in, .parallel_in, .capture_edge_select,
      .serial_output_enable, .sleep_request_n, .align_request_a, .align_request_b,
      .serial_out_p, .serial_out_n, .serial_oe_n);
   sfs_rx_model sfs_rx_model_inst (.receiver_local_clock(core_clk), .nrst,
      .line_p(serial_out_p), .line_oe_n(serial_oe_n), .lock_n, .rx_valid,
      .receiver_parallel_out(rx_word));

   // ----------------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task stop_test;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wait_lock;
      n = 0;
      while (serial_oe_n) begin
         @(posedge tx_clock_in);
         n++;
      end
      chk(32'(n >= 510 && n <= 513), 1);
   endtask

   task wait_pay;
      got_pay = 0;
      wait (got_pay);
   endtask

   function logic [9:0] rnd;
      logic [9:0] w;
      w = 10'($urandom);
      return (w == `SFS_ALIGN_PATTERN) ? ~w : w;
   endfunction

   // ----------------------------------------------------------------------
   // Clocks, parallel stimulus and frame checking
   // ----------------------------------------------------------------------
   initial begin
      core_clk = 0;
      forever #2 core_clk = ~core_clk;
   end
   initial begin
      tx_clock_in = 0;
      #7;
      forever #40 tx_clock_in = ~tx_clock_in;
   end
   always @(posedge core_clk) if (++cyc == 95000) begin
      fails++;
      stop_test;
   end
   always @(tx_clock_in) begin
      if (chk_on && tx_clock_in === capture_edge_select) exq.push_back(parallel_in);
      parallel_in <= rnd();
   end
   always @(posedge core_clk) begin
      if (rx_valid && rx_word === `SFS_ALIGN_PATTERN) n_align++;
      else if (rx_valid && !lock_n) begin
         got_pay = 1;
         if (chk_on && exq.size() > 0) begin
            if (exq[0] === rx_word) resync = 0;
            if (!resync) chk(32'(rx_word), 32'(exq.pop_front()));
            else if (++skip > 3) chk(32'(rx_word), 32'(exq[0]));
         end
      end
   end

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      nrst = 0;
      capture_edge_select = 1;
      serial_output_enable = 1;
      sleep_request_n = 1;
      align_request_b = 0;
      chk_on = 0;
      void'($urandom(12));
      repeat (10) @(posedge core_clk);
      nrst <= 1;
      repeat (2) @(posedge core_clk);
      apb(0, `SFS_CTRL_OFFSET, 0);
      chk(rd, 32'h2);
      apb(1, `SFS_CTRL_OFFSET, 32'h3);
      apb(0, `SFS_CTRL_OFFSET, 0);
      chk(rd, 32'h3);
      apb(0, `SFS_STATUS_OFFSET, 0);
      chk(32'(rd[1]), 1);
      apb(1, `SFS_CTRL_OFFSET, 32'h2);
      apb(0, 8'h0C, 0);
      chk({er, rd[30:0]}, 32'h80000000);
      $display("test registers done");
      wait_lock;
      $display("test lock done");
      wait_pay;
      for (int e = 1; e >= 0; e--) begin
         chk_on = 0;
         exq.delete();
         capture_edge_select <= e[0];
         repeat (4) @(posedge tx_clock_in);
         resync = 1;
         skip = 0;
         k = n_tests;
         chk_on = 1;
         repeat (40) @(posedge tx_clock_in);
         chk(32'(n_tests - k >= 36), 1);
      end
      chk_on = 0;
      $display("test payload done");
      n_align = 0;
      align_request_b <= 1;
      repeat (5) @(posedge tx_clock_in);
      align_request_b <= 0;
      wait_pay;
      chk(32'(n_align >= 1024), 1);
      $display("test alignment done");
      serial_output_enable <= 0;
      repeat (10) @(posedge core_clk);
      chk(32'(serial_oe_n), 1);
      chk(32'(serial_out_n), 1);
      chk(32'(lock_n), 1);
      apb(0, `SFS_STATUS_OFFSET, 0);
      chk(32'(rd[2]), 1);
      n_align = 0;
      serial_output_enable <= 1;
      wait_pay;
      chk(32'(n_align >= 1024), 1);
      $display("test high impedance done");
      sleep_request_n <= 0;
      repeat (10) @(posedge core_clk);
      chk(32'(serial_oe_n), 1);
      apb(0, `SFS_STATUS_OFFSET, 0);
      chk(32'(rd[0]), 0);
      sleep_request_n <= 1;
      wait_lock;
      $display("test sleep done");
      stop_test;
   end
endmodule

`default_nettype wire
